// File: include/sbsr_pkg.sv
// Purpose : shared constants and carriers of the status byte / service request block
// Assumes : one 10 MHz clock, asynchronous active-low reset
// Notes   : command codes are those the upstream command parser presents
package sbsr_pkg;

    // ****************************************************************
    // widths and bit positions
    // ****************************************************************
    localparam int          GRP_W      = 16;
    localparam int          DATA_W     = 16;
    localparam int          DIGITS     = 5;
    localparam int          BIT_ISUM   = 1;
    localparam int          BIT_CSUM   = 2;
    localparam int          BIT_HSUM   = 3;
    localparam int          BIT_MAV    = 4;
    localparam int          BIT_ESB    = 5;
    localparam int          BIT_MSS    = 6;
    localparam int          BIT_ERB    = 7;

    // ****************************************************************
    // reset values and fixed transition filters (1 = positive-going)
    // ****************************************************************
    localparam logic [7:0]  RST_BYTE   = 8'h00;
    localparam logic [15:0] RST_WORD   = 16'h0000;
    localparam logic [7:0]  MASK_KEEP  = 8'hbf;
    localparam logic [15:0] HW_RISE    = 16'hffff;
    localparam logic [15:0] CPL_RISE   = 16'hffff;
    localparam logic [15:0] INS_RISE   = 16'h0000;
    localparam logic [7:0]  ASCII_ZERO = 8'h30;

    // ****************************************************************
    // commands and queries
    // ****************************************************************
    typedef enum logic [4:0] {
        SBSR_CLEAR_STATUS              = 5'h00,
        SBSR_STD_ENABLE_WRITE          = 5'h01,
        SBSR_STD_ENABLE_QUERY          = 5'h02,
        SBSR_STD_EVENT_QUERY           = 5'h03,
        SBSR_SVC_MASK_WRITE            = 5'h04,
        SBSR_SVC_MASK_QUERY            = 5'h05,
        SBSR_SUMMARY_QUERY             = 5'h06,
        SBSR_COUPLING_CONDITION_QUERY  = 5'h07,
        SBSR_COUPLING_ENABLE_COMMAND   = 5'h08,
        SBSR_COUPLING_ENABLE_QUERY     = 5'h09,
        SBSR_COUPLING_EVENT_QUERY      = 5'h0a,
        SBSR_HARDWARE_CONDITION_QUERY  = 5'h0b,
        SBSR_HARDWARE_ENABLE_COMMAND   = 5'h0c,
        SBSR_HARDWARE_ENABLE_QUERY     = 5'h0d,
        SBSR_HARDWARE_EVENT_QUERY      = 5'h0e,
        SBSR_INSTRUMENT_CONDITION_QUERY = 5'h0f,
        SBSR_INSTRUMENT_ENABLE_COMMAND = 5'h10,
        SBSR_INSTRUMENT_ENABLE_QUERY   = 5'h11,
        SBSR_INSTRUMENT_EVENT_QUERY    = 5'h12
    } sbsr_cmd_e;

    typedef struct packed {
        sbsr_cmd_e          code;
        logic [DATA_W-1:0]  data;
    } sbsr_cmd_s;

    typedef struct packed {
        logic               valid;
        logic               last;
        logic [7:0]         char;
    } sbsr_char_s;

endpackage

// File: hw/sbsr_nr1_fmt.sv
// Purpose : turn an unsigned value into nr1 decimal ascii, most significant digit first
// Assumes : value fits DIGITS decimal digits
// Notes   : leading zeros suppressed, zero is sent as a single '0'
module sbsr_nr1_fmt
    import sbsr_pkg::*;
(
    input  wire logic                       clock_i,
    input  wire logic                       rst_n_i,
    input  wire logic                       start_i,
    input  wire logic [sbsr_pkg::DATA_W-1:0] value_i,
    input  wire logic                       char_ready_i,
    output sbsr_pkg::sbsr_char_s            char_o,
    output logic                            busy_o
);
    import sbsr_pkg::*;

    typedef struct packed {
        logic                   active;
        logic [2:0]             idx;
        logic [DIGITS-1:0][3:0] dig;
    } sbsr_fmt_s;

    sbsr_fmt_s s_r;
    sbsr_fmt_s s_nxt;

    // ****************************************************************
    // decimal split
    // ****************************************************************
    function automatic logic [DIGITS-1:0][3:0] to_dec(input logic [DATA_W-1:0] v);
        logic [DIGITS-1:0][3:0] d;
        logic [DATA_W-1:0]      r;
        r = v;
        for (int i = 0; i < DIGITS; i++) begin
            d[i] = 4'(r % 16'd10);
            r    = r / 16'd10;
        end
        return d;
    endfunction

    always_comb begin
        logic [DIGITS-1:0][3:0] d;
        d     = to_dec(value_i);
        s_nxt = s_r;
        if (s_r.active && char_ready_i) begin
            if (s_r.idx == 3'h0) begin
                s_nxt.active = 1'b0;
            end else begin
                s_nxt.idx = s_r.idx - 3'h1;
            end
        end else if (!s_r.active && start_i) begin
            s_nxt.active = 1'b1;
            s_nxt.dig    = d;
            s_nxt.idx    = 3'h0;
            for (int i = 1; i < DIGITS; i++) begin
                if (d[i] != 4'h0) begin
                    s_nxt.idx = 3'(i);
                end
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign busy_o       = s_r.active;
    assign char_o.valid = s_r.active;
    assign char_o.last  = s_r.idx == 3'h0;
    assign char_o.char  = ASCII_ZERO + {4'h0, s_r.dig[s_r.idx]};

    AST_NR1_DIGIT: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        s_r.active |-> (char_o.char >= 8'h30 && char_o.char <= 8'h39))
        else $error("nr1 character is not a decimal digit");

endmodule

// File: hw/sbsr_status_core.sv
// Purpose : status byte, service request mask, event groups and service request flag
// Assumes : commands come decoded from the parser; inputs synchronous to clock_i
// Notes   : query answers leave as nr1 ascii characters through the formatter
// Summary of operation
// - bit 6 of the service request mask ignores writes, reads back 0
// - master summary true when status byte AND mask is non-zero
// - bit 7 high exactly while the error queue is non-empty
// - bit 4 high exactly while the output queue holds a byte
// - the summary query clears nothing
// - a new reason for service sets the request flag
// - request flag clears when master summary falls or on a serial poll in a cycle with no new reason
// - the service request line follows the request flag
// - hardware, coupling and instrument groups each have a summary bit
// - standard event summary appears as the esb bit
// - clear-status clears all event registers and empties the error queue
// - standard event enable writable and readable, event register readable
// - each group has condition query, enable write and readback, event query
// - every query answers as an unsigned decimal nr1 number
// - bits 7, 5, 4 error, event, message; bits 1-3 groups; bit 0 unused
// - event bits latch until read or clear-status
// - enable registers survive clear-status and clear at power-on
// - each group event bit has a fixed rising or falling transition filter, standard event inputs latch on level
module sbsr_status_core
    import sbsr_pkg::*;
#(
    parameter int          GW      = sbsr_pkg::GRP_W,
    parameter logic [15:0] HW_POS  = sbsr_pkg::HW_RISE,
    parameter logic [15:0] CPL_POS = sbsr_pkg::CPL_RISE,
    parameter logic [15:0] INS_POS = sbsr_pkg::INS_RISE
)
(
    input  wire logic                  clock_i,
    input  wire logic                  rst_n_i,
    input  wire logic                  cmd_valid_i,
    input  sbsr_pkg::sbsr_cmd_s        cmd_i,
    output logic                       cmd_ready_o,
    input  wire logic [GW-1:0]         hw_cond_i,
    input  wire logic [GW-1:0]         cpl_cond_i,
    input  wire logic [GW-1:0]         ins_cond_i,
    input  wire logic [7:0]            std_event_i,
    input  wire logic                  err_queue_nonempty_i,
    input  wire logic                  out_queue_nonempty_i,
    input  wire logic                  serial_poll_i,
    output logic [7:0]                 poll_byte_o,
    output logic                       poll_valid_o,
    output logic                       srq_o,
    output logic                       err_queue_clear_o,
    input  wire logic                  char_ready_i,
    output sbsr_pkg::sbsr_char_s       char_o
);
    import sbsr_pkg::*;

    if (GW < 1 || GW > 16) begin : g_bad_width
        $error("group width must be 1 to 16");
    end

    typedef struct packed {
        logic [GW-1:0] hw_prev, cpl_prev, ins_prev;
        logic [GW-1:0] hw_ev, cpl_ev, ins_ev;
        logic [GW-1:0] hw_en, cpl_en, ins_en;
        logic [7:0]    std_ev, std_en, svc_mask, mss_vec, poll_byte;
        logic          rqs, poll_valid, err_clr;
    } sbsr_core_s;

    sbsr_core_s           s_r;
    sbsr_core_s           s_nxt;
    logic                 take;
    logic                 fmt_busy;
    logic                 fmt_start;
    logic [DATA_W-1:0]    answer;
    logic [7:0]           stb;
    logic [7:0]           mss_vec;
    logic                 mss;
    logic                 new_reason;

    // ****************************************************************
    // transition filter
    // ****************************************************************
    function automatic logic [GW-1:0] edges(input logic [GW-1:0] cur,
                                            input logic [GW-1:0] prev,
                                            input logic [GW-1:0] pos);
        return (pos & cur & ~prev) | (~pos & ~cur & prev);
    endfunction

    function automatic logic [DATA_W-1:0] widen(input logic [GW-1:0] v);
        return DATA_W'(v);
    endfunction

    // ****************************************************************
    // status byte and service request
    // ****************************************************************
    always_comb begin
        stb            = RST_BYTE;
        stb[BIT_ERB]   = err_queue_nonempty_i;
        stb[BIT_ESB]   = |(s_r.std_ev & s_r.std_en);
        stb[BIT_MAV]   = out_queue_nonempty_i;
        stb[BIT_HSUM]  = |(s_r.hw_ev & s_r.hw_en);
        stb[BIT_CSUM]  = |(s_r.cpl_ev & s_r.cpl_en);
        stb[BIT_ISUM]  = |(s_r.ins_ev & s_r.ins_en);
        mss_vec        = stb & s_r.svc_mask;
        mss            = mss_vec != 8'h00;
        // a bit joining the AND is a new reason, whether the byte or the mask moved
        new_reason     = (mss_vec & ~s_r.mss_vec) != 8'h00;
    end

    assign take        = cmd_valid_i && !fmt_busy;
    assign cmd_ready_o = !fmt_busy;

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        logic [GW-1:0] hw_clr, cpl_clr, ins_clr;
        logic [7:0]    std_clr;
        hw_clr    = '0;
        cpl_clr   = '0;
        ins_clr   = '0;
        std_clr   = 8'h00;
        s_nxt     = s_r;
        answer    = '0;
        fmt_start = 1'b0;
        s_nxt.err_clr    = 1'b0;
        s_nxt.poll_valid = 1'b0;
        if (take) begin
            fmt_start = 1'b1;
            case (cmd_i.code)
                SBSR_CLEAR_STATUS: begin
                    fmt_start     = 1'b0;
                    hw_clr        = '1;
                    cpl_clr       = '1;
                    ins_clr       = '1;
                    std_clr       = 8'hff;
                    s_nxt.err_clr = 1'b1;
                end
                SBSR_STD_ENABLE_WRITE: begin
                    fmt_start     = 1'b0;
                    s_nxt.std_en  = cmd_i.data[7:0];
                end
                SBSR_STD_ENABLE_QUERY: answer = {8'h00, s_r.std_en};
                SBSR_STD_EVENT_QUERY: begin
                    answer  = {8'h00, s_r.std_ev};
                    std_clr = 8'hff;
                end
                SBSR_SVC_MASK_WRITE: begin
                    fmt_start      = 1'b0;
                    s_nxt.svc_mask = cmd_i.data[7:0] & MASK_KEEP;
                end
                SBSR_SVC_MASK_QUERY: answer = {8'h00, s_r.svc_mask};
                // mss replaces bit 6 here, nothing is cleared by this read
                SBSR_SUMMARY_QUERY: answer = {8'h00, stb | {1'b0, mss, 6'h00}};
                SBSR_COUPLING_CONDITION_QUERY: answer = widen(cpl_cond_i);
                SBSR_COUPLING_ENABLE_COMMAND: begin
                    fmt_start     = 1'b0;
                    s_nxt.cpl_en  = cmd_i.data[GW-1:0];
                end
                SBSR_COUPLING_ENABLE_QUERY: answer = widen(s_r.cpl_en);
                SBSR_COUPLING_EVENT_QUERY: begin
                    answer  = widen(s_r.cpl_ev);
                    cpl_clr = '1;
                end
                SBSR_HARDWARE_CONDITION_QUERY: answer = widen(hw_cond_i);
                SBSR_HARDWARE_ENABLE_COMMAND: begin
                    fmt_start    = 1'b0;
                    s_nxt.hw_en  = cmd_i.data[GW-1:0];
                end
                SBSR_HARDWARE_ENABLE_QUERY: answer = widen(s_r.hw_en);
                SBSR_HARDWARE_EVENT_QUERY: begin
                    answer = widen(s_r.hw_ev);
                    hw_clr = '1;
                end
                SBSR_INSTRUMENT_CONDITION_QUERY: answer = widen(ins_cond_i);
                SBSR_INSTRUMENT_ENABLE_COMMAND: begin
                    fmt_start    = 1'b0;
                    s_nxt.ins_en = cmd_i.data[GW-1:0];
                end
                SBSR_INSTRUMENT_ENABLE_QUERY: answer = widen(s_r.ins_en);
                SBSR_INSTRUMENT_EVENT_QUERY: begin
                    answer  = widen(s_r.ins_ev);
                    ins_clr = '1;
                end
                default: fmt_start = 1'b0;
            endcase
        end
        // set wins over clear so an edge arriving during a read is kept
        s_nxt.hw_ev  = (s_r.hw_ev & ~hw_clr)
                     | edges(hw_cond_i, s_r.hw_prev, HW_POS[GW-1:0]);
        s_nxt.cpl_ev = (s_r.cpl_ev & ~cpl_clr)
                     | edges(cpl_cond_i, s_r.cpl_prev, CPL_POS[GW-1:0]);
        s_nxt.ins_ev = (s_r.ins_ev & ~ins_clr)
                     | edges(ins_cond_i, s_r.ins_prev, INS_POS[GW-1:0]);
        s_nxt.std_ev = (s_r.std_ev & ~std_clr) | std_event_i;
        s_nxt.hw_prev  = hw_cond_i;
        s_nxt.cpl_prev = cpl_cond_i;
        s_nxt.ins_prev = ins_cond_i;
        s_nxt.mss_vec  = mss_vec;
        if (new_reason) begin
            s_nxt.rqs = 1'b1;
        end else if (!mss || serial_poll_i) begin
            s_nxt.rqs = 1'b0;
        end
        if (serial_poll_i) begin
            s_nxt.poll_byte  = stb | {1'b0, s_r.rqs, 6'h00};
            s_nxt.poll_valid = 1'b1;
        end
    end

    // enables clear only here, at reset, never on clear-status
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign srq_o             = s_r.rqs;
    assign poll_byte_o       = s_r.poll_byte;
    assign poll_valid_o      = s_r.poll_valid;
    assign err_queue_clear_o = s_r.err_clr;

    sbsr_nr1_fmt u_fmt (
        .clock_i      (clock_i),
        .rst_n_i      (rst_n_i),
        .start_i      (fmt_start),
        .value_i      (answer),
        .char_ready_i (char_ready_i),
        .char_o       (char_o),
        .busy_o       (fmt_busy)
    );

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    AST_MASK_BIT6: assert property (take && cmd_i.code == SBSR_SVC_MASK_WRITE
        |=> !s_r.svc_mask[BIT_MSS])
        else $error("mask bit 6 was stored");
    AST_MSS_SETS_RQS: assert property ($rose(mss) |=> s_r.rqs)
        else $error("master summary rose without a service request");
    // ties the polled byte to the queue input rather than to the internal byte
    AST_ERB_FOLLOWS: assert property (serial_poll_i
        |=> poll_byte_o[BIT_ERB] == $past(err_queue_nonempty_i))
        else $error("error summary missing");
    AST_SUMMARY_NO_CLEAR: assert property (take && cmd_i.code == SBSR_SUMMARY_QUERY
        |=> (($past(s_r.hw_ev) & ~s_r.hw_ev) == '0)
        && (($past(s_r.std_ev) & ~s_r.std_ev) == 8'h00))
        else $error("summary query cleared an event");
    AST_RQS_CLEAR: assert property (!new_reason && (serial_poll_i || !mss) |=> !s_r.rqs)
        else $error("request flag not cleared");
    AST_SRQ_LINE: assert property (new_reason |=> srq_o ##0 s_r.rqs)
        else $error("service request line not raised");
    AST_CLS_QUEUE: assert property (take && cmd_i.code == SBSR_CLEAR_STATUS
        && std_event_i == 8'h00 |=> err_queue_clear_o && s_r.std_ev == 8'h00
        ##1 !err_queue_clear_o)
        else $error("clear-status did not clear");
    AST_ENABLE_KEEP: assert property (take && cmd_i.code == SBSR_CLEAR_STATUS
        |=> $stable(s_r.hw_en) && $stable(s_r.std_en) && $stable(s_r.svc_mask))
        else $error("clear-status touched an enable");
    AST_LATCH: assert property (!(take && cmd_i.code inside {SBSR_CLEAR_STATUS,
        SBSR_HARDWARE_EVENT_QUERY}) |=> (($past(s_r.hw_ev) & ~s_r.hw_ev) == '0))
        else $error("hardware event bit dropped");
    AST_FILTER: assert property (HW_POS[0] && hw_cond_i[0] && !s_r.hw_prev[0]
        |=> s_r.hw_ev[0])
        else $error("positive edge not latched");

    COV_RQS: cover property (!s_r.rqs ##1 s_r.rqs);
    COV_POLL: cover property (s_r.rqs && serial_poll_i ##1 poll_valid_o);
    COV_QUERY: cover property (take && cmd_i.code == SBSR_SUMMARY_QUERY ##[1:8] char_o.last);
    COV_CLS: cover property (take && cmd_i.code == SBSR_CLEAR_STATUS);

endmodule

// File: bench/sbsr_gpib_ctrl.sv
// Purpose : bus controller model that sends commands, reads answers and runs serial polls
// Assumes : every request changes 1 ns after a rising edge and holds until it is taken
// Notes   : answer characters are accepted with random stalls to load the character handshake
module sbsr_gpib_ctrl
    import sbsr_pkg::*;
(
    input  wire logic             clock_i,
    input  wire logic             cmd_ready_i,
    input  sbsr_pkg::sbsr_char_s  char_i,
    input  wire logic             poll_valid_i,
    input  wire logic [7:0]       poll_byte_i,
    output logic                  cmd_valid_o,
    output sbsr_pkg::sbsr_cmd_s   cmd_o,
    output logic                  serial_poll_o,
    output logic                  char_ready_o
);
    timeunit 1ns;
    timeprecision 100ps;
    int timeouts = 0;
    initial begin
        cmd_valid_o = 1'b0;
        cmd_o = '0;
        serial_poll_o = 1'b0;
        char_ready_o = 1'b0;
    end
    // ****************************************************************
    // command handshake
    // ****************************************************************
    task automatic send(input sbsr_cmd_e code, input logic [15:0] data);
        int n;
        @(posedge clock_i);
        #1 cmd_valid_o = 1'b1;
        cmd_o = {code, data};
        for (n = 0; n < 100 && cmd_ready_i !== 1'b1; n++) begin
            @(posedge clock_i);
            #1;
        end
        if (n == 100) timeouts++;
        @(posedge clock_i);
        #1 cmd_valid_o = 1'b0;
        // released data must not keep looking valid
        cmd_o.data = ~data;
    endtask
    // ****************************************************************
    // answer collection, decimal digits most significant first
    // ****************************************************************
    // four-state result so an unknown character cannot pass as a digit
    task automatic query(input sbsr_cmd_e code, output logic [31:0] val);
        int n;
        logic acc;
        logic lst;
        logic [7:0] ch;
        send(code, 16'($urandom));
        val = 0;
        for (n = 0; n < 200; n++) begin
            char_ready_o = ($urandom_range(3) != 0);
            acc = char_i.valid & char_ready_o;
            lst = char_i.last;
            ch = char_i.char;
            @(posedge clock_i);
            #1;
            if (acc === 1'b1) val = val * 32'd10 + {24'h000000, ch - 8'h30};
            if (acc === 1'b1 && lst === 1'b1) break;
        end
        if (n == 200) timeouts++;
        char_ready_o = 1'b0;
    endtask
    task automatic poll(output logic [7:0] b, output logic v);
        @(posedge clock_i);
        #1 serial_poll_o = 1'b1;
        @(posedge clock_i);
        #1 serial_poll_o = 1'b0;
        v = poll_valid_i;
        b = poll_byte_i;
    endtask
endmodule

// File: bench/status_byte_service_request_bench.sv
// Purpose : self-checking bench of the status byte and service request core
// Assumes : inputs change 1 ns after a rising edge
// Notes   : expected values come from copies of the registers kept in this bench
module status_byte_service_request_bench
    import sbsr_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic          clock_i = 1'b0;
    logic          rst_n_i = 1'b0;
    logic          cmd_valid, cmd_ready, spoll, poll_valid, srq, err_clr, char_ready;
    logic          erq = 1'b0, oq = 1'b0, erb = 1'b0, mav = 1'b0;
    logic [15:0]   hw = '0, cpl = '0, ins = '0, mask = '0;
    logic [7:0]    std_ev = '0, poll_byte;
    logic [15:0]   ev[4], en[4];
    sbsr_cmd_s     cmd;
    sbsr_char_s    chr;
    int            failures = 0, checks = 0;
    sbsr_cmd_e     wr_c[4] = '{SBSR_STD_ENABLE_WRITE, SBSR_HARDWARE_ENABLE_COMMAND,
                               SBSR_COUPLING_ENABLE_COMMAND, SBSR_INSTRUMENT_ENABLE_COMMAND};
    sbsr_cmd_e     rd_c[4] = '{SBSR_STD_ENABLE_QUERY, SBSR_HARDWARE_ENABLE_QUERY,
                               SBSR_COUPLING_ENABLE_QUERY, SBSR_INSTRUMENT_ENABLE_QUERY};
    sbsr_cmd_e     ev_c[4] = '{SBSR_STD_EVENT_QUERY, SBSR_HARDWARE_EVENT_QUERY,
                               SBSR_COUPLING_EVENT_QUERY, SBSR_INSTRUMENT_EVENT_QUERY};
    sbsr_cmd_e     cd_c[3] = '{SBSR_HARDWARE_CONDITION_QUERY, SBSR_COUPLING_CONDITION_QUERY,
                               SBSR_INSTRUMENT_CONDITION_QUERY};
    always #50 clock_i = ~clock_i;
    sbsr_status_core dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .cmd_valid_i(cmd_valid),
        .cmd_i(cmd), .cmd_ready_o(cmd_ready), .hw_cond_i(hw), .cpl_cond_i(cpl),
        .ins_cond_i(ins), .std_event_i(std_ev), .err_queue_nonempty_i(erq),
        .out_queue_nonempty_i(oq), .serial_poll_i(spoll), .poll_byte_o(poll_byte),
        .poll_valid_o(poll_valid), .srq_o(srq), .err_queue_clear_o(err_clr),
        .char_ready_i(char_ready), .char_o(chr));
    sbsr_gpib_ctrl ctrl (.clock_i(clock_i), .cmd_ready_i(cmd_ready), .char_i(chr),
        .poll_valid_i(poll_valid), .poll_byte_i(poll_byte), .cmd_valid_o(cmd_valid),
        .cmd_o(cmd), .serial_poll_o(spoll), .char_ready_o(char_ready));
    // ****************************************************************
    // reference model and helpers
    // ****************************************************************
    function automatic logic [7:0] sb();
        return {erb, 1'b0, |(ev[0] & en[0]), mav, |(ev[1] & en[1]), |(ev[2] & en[2]),
                |(ev[3] & en[3]), 1'b0};
    endfunction
    function automatic logic [15:0] summ();
        return {8'h00, sb() | {1'b0, |(sb() & mask[7:0]), 6'h00}};
    endfunction
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic q(input sbsr_cmd_e c, input logic [15:0] e);
        logic [31:0] v;
        ctrl.query(c, v);
        chk(c.name(), e, v[15:0]);
    endtask
    task automatic qev(input int k);
        q(ev_c[k], ev[k]);
        ev[k] = '0;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask
    task automatic pulse_std(input logic [7:0] v);
        ev[0] |= {8'h00, v};
        @(posedge clock_i);
        #1 std_ev = v;
        @(posedge clock_i);
        #1 std_ev = 8'h00;
    endtask
    // hardware and coupling latch rising edges, instrument latches falling edges
    task automatic set_cond(input logic [15:0] h, c, i, input logic e, o);
        ev[1] |= h & ~hw;
        ev[2] |= c & ~cpl;
        ev[3] |= ins & ~i;
        erb = e;
        mav = o;
        @(posedge clock_i);
        #1 {hw, cpl, ins, erq, oq} = {h, c, i, e, o};
        tick(3);
    endtask
    task automatic wrap_up();
        failures += ctrl.timeouts;
        if (failures == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        #2000000;
        failures++;
        wrap_up();
    end
    // ****************************************************************
    // scenarios
    // ****************************************************************
    initial begin
        logic [15:0] v;
        logic [7:0]  pb;
        logic        pv;
        void'($urandom(32'h9880b3c0));
        ev = '{default: '0};
        en = '{default: '0};
        tick(8);
        rst_n_i = 1'b1;
        q(SBSR_SVC_MASK_QUERY, 16'h0000);
        q(SBSR_SUMMARY_QUERY, 16'h0000);
        for (int r = 0; r < 4; r++) begin
            for (int k = 0; k < 4; k++) begin
                v = 16'($urandom) | 16'h0001;
                if (k == 0) v &= 16'h00ff;
                ctrl.send(wr_c[k], v);
                en[k] = v;
                q(rd_c[k], en[k]);
            end
            v = 16'($urandom & 32'h00ff) | 16'h0040;
            ctrl.send(SBSR_SVC_MASK_WRITE, v);
            mask = v & 16'h00bf;
            q(SBSR_SVC_MASK_QUERY, mask);
            pulse_std(8'($urandom));
            set_cond(16'($urandom), 16'($urandom), 16'($urandom), 1'($urandom), 1'($urandom));
            q(cd_c[0], hw);
            q(cd_c[1], cpl);
            q(cd_c[2], ins);
            repeat (2) q(SBSR_SUMMARY_QUERY, summ());
            for (int k = 0; k < 4; k++) begin
                qev(k);
                qev(k);
            end
        end
        ctrl.send(SBSR_SVC_MASK_WRITE, 16'h0000);
        mask = '0;
        ctrl.send(SBSR_HARDWARE_ENABLE_COMMAND, 16'h0001);
        en[1] = 16'h0001;
        // start from a low condition so the next step is a real rising edge
        set_cond(16'h0000, 16'h0000, 16'h0000, 1'b0, 1'b0);
        set_cond(16'h0001, 16'h0000, 16'h0000, 1'b0, 1'b0);
        chk("srq", 1'b0, srq);
        ctrl.send(SBSR_SVC_MASK_WRITE, 16'h0008);
        mask = 16'h0008;
        tick(3);
        chk("srq", 1'b1, srq);
        ctrl.poll(pb, pv);
        chk("poll valid", 1'b1, pv);
        chk("poll byte", sb() | 8'h40, pb);
        tick(2);
        chk("srq", 1'b0, srq);
        qev(1);
        set_cond(16'h0000, 16'h0000, 16'h0000, 1'b0, 1'b0);
        set_cond(16'h0001, 16'h0000, 16'h0000, 1'b0, 1'b0);
        chk("srq", 1'b1, srq);
        qev(1);
        tick(3);
        chk("srq", 1'b0, srq);
        pulse_std(8'hff);
        set_cond(16'hffff, 16'hffff, 16'h0000, 1'b1, 1'b1);
        ctrl.send(SBSR_CLEAR_STATUS, 16'h0000);
        chk("queue clear", 1'b1, err_clr);
        ev = '{default: '0};
        tick(1);
        chk("queue clear", 1'b0, err_clr);
        set_cond(16'hffff, 16'hffff, 16'h0000, 1'b0, 1'b1);
        // an unknown code is taken and must change nothing
        ctrl.send(sbsr_cmd_e'(5'h1f), 16'hffff);
        for (int k = 0; k < 4; k++) begin
            qev(k);
            q(rd_c[k], en[k]);
        end
        q(SBSR_SUMMARY_QUERY, summ());
        wrap_up();
    end
endmodule
